// [rtl/muldiv_regs.sv]
// operand and result byte registers of the multiply/divide unit
`default_nettype none
module muldiv_regs import muldiv_pkg::*; #(
    parameter int VALUE_W = 32,
    parameter int OPER_W = 16
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // status
    output logic BUSY
);

    // refused at elaboration: the byte map only serves the documented widths
    if (VALUE_W != VALUE_WIDTH || OPER_W != OPER_WIDTH) begin : g_bad_widths
        $error("muldiv_regs: unsupported widths");
    end

    // ****************************************
    // storage
    // ****************************************
    logic [7:0] byte_reg [0:5];
    logic [5:0] ctrl_reg;
    logic ovf_reg;
    op_t last_op_reg;
    seq_t seq_reg;
    seq_t seq_next;
    logic start_next;
    op_t op_next;
    eng_req_t req;
    eng_resp_t resp;
    logic [7:0] rdata_next;

    logic wr_b0;
    logic wr_b1;
    logic wr_b2;
    logic wr_b3;
    logic wr_b4;
    logic wr_b5;
    logic wr_ctrl;
    logic wr_ok;

    // writes while the engine runs are dropped so operands stay consistent
    assign wr_ok = WR && !resp.busy;
    assign wr_b0 = wr_ok && ADDR == ADDR_BYTE0;
    assign wr_b1 = wr_ok && ADDR == ADDR_BYTE1;
    assign wr_b2 = wr_ok && ADDR == ADDR_BYTE2;
    assign wr_b3 = wr_ok && ADDR == ADDR_BYTE3;
    assign wr_b4 = wr_ok && ADDR == ADDR_DIVISOR_LOW;
    assign wr_b5 = wr_ok && ADDR == ADDR_DIVISOR_HIGH;
    assign wr_ctrl = wr_ok && ADDR == ADDR_ARITH_CONTROL;

    // ****************************************
    // operation detection from write order
    // ****************************************
    always_comb begin
        seq_next = seq_reg;
        start_next = 1'b0;
        op_next = OP_NONE;
        if (wr_b0) begin
            seq_next = SEQ_W0; // see RL10
        end else if (wr_ok) begin
            seq_next = SEQ_IDLE;
            case (seq_reg)
                SEQ_W0: begin
                    if (wr_b1) seq_next = SEQ_W01;
                    else if (wr_b4) seq_next = SEQ_W04;
                end
                SEQ_W01: begin
                    if (wr_b2) seq_next = SEQ_W012;
                    else if (wr_b4) seq_next = SEQ_W01_4;
                end
                SEQ_W012: if (wr_b3) seq_next = SEQ_W0123;
                SEQ_W0123: begin
                    if (wr_b4) begin
                        seq_next = SEQ_W0123_4;
                    end else if (wr_ctrl) begin
                        start_next = 1'b1;
                        op_next = OP_SHIFT;
                    end
                end
                SEQ_W0123_4: begin
                    if (wr_b5) begin
                        start_next = 1'b1;
                        op_next = OP_DIV32;
                    end
                end
                SEQ_W01_4: begin
                    if (wr_b5) begin
                        start_next = 1'b1;
                        op_next = OP_DIV16;
                    end
                end
                SEQ_W04: if (wr_b1) seq_next = SEQ_W04_1;
                SEQ_W04_1: begin
                    if (wr_b5) begin
                        start_next = 1'b1;
                        op_next = OP_MUL;
                    end
                end
                default: seq_next = SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            seq_reg <= seq_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            last_op_reg <= OP_NONE;
        end else if (start_next) begin
            last_op_reg <= op_next; // see RL2
        end
    end

    // ****************************************
    // engine hookup
    // ****************************************
    always_comb begin
        req.start = start_next;
        req.op = op_next;
        // divide 16/16 takes only the two low dividend bytes
        if (op_next == OP_DIV16 || op_next == OP_MUL) begin
            req.value = {16'h0000, byte_reg[1], byte_reg[0]};
        end else begin
            req.value = {byte_reg[3], byte_reg[2], byte_reg[1], byte_reg[0]};
        end
        // the high operand byte arrives with the starting write, not yet in its register
        req.operand = {(wr_b5 ? WDATA : byte_reg[5]), byte_reg[4]}; // see RL9
        // control written in the starting cycle is used at once
        req.count = WDATA[CTRL_COUNT_MSB:0];
        req.dir_right = WDATA[CTRL_DIR_BIT];
    end

    muldiv_engine #(
        .VALUE_W(VALUE_W),
        .OPER_W(OPER_W)
    ) engine (
        .clk(CLK),
        .rst(RST),
        .req(req),
        .resp(resp)
    );

    // ****************************************
    // byte registers: operands in, results back
    // ****************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < 6; i++) begin
                byte_reg[i] <= BYTE_RESET; // see RL1
            end
        end else if (resp.done) begin
            byte_reg[0] <= resp.value[7:0]; // see RL3 RL4
            byte_reg[1] <= resp.value[15:8]; // see RL5 RL6
            byte_reg[2] <= resp.value[23:16]; // see RL7
            byte_reg[3] <= resp.value[31:24]; // see RL8
            if (last_op_reg == OP_DIV32 || last_op_reg == OP_DIV16) begin
                byte_reg[4] <= resp.rem[7:0]; // see RL9
                byte_reg[5] <= resp.rem[15:8]; // see RL9
            end
        end else begin
            if (wr_b0) byte_reg[0] <= WDATA; // see RL3 RL4
            if (wr_b1) byte_reg[1] <= WDATA; // see RL5 RL6
            if (wr_b2) byte_reg[2] <= WDATA; // see RL7
            if (wr_b3) byte_reg[3] <= WDATA; // see RL8
            if (wr_b4) byte_reg[4] <= WDATA; // see RL9
            if (wr_b5) byte_reg[5] <= WDATA; // see RL9
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_reg <= CTRL_RW_RESET;
        end else if (resp.done && last_op_reg == OP_SHIFT && ctrl_reg[CTRL_COUNT_MSB:0] == 5'h00) begin
            // normalize reports how far it shifted
            ctrl_reg[CTRL_COUNT_MSB:0] <= resp.count;
        end else if (wr_ctrl) begin
            ctrl_reg <= WDATA[5:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ovf_reg <= 1'b0;
        end else if (resp.done) begin
            ovf_reg <= resp.overflow;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_comb begin
        rdata_next = READ_UNMAPPED;
        // results are only meaningful once the engine is idle
        if (!resp.busy) begin
            case (ADDR)
                ADDR_BYTE0: rdata_next = byte_reg[0]; // see RL3 RL4
                ADDR_BYTE1: rdata_next = byte_reg[1]; // see RL5 RL6
                ADDR_BYTE2: if (last_op_reg != OP_DIV16) rdata_next = byte_reg[2]; // see RL7
                ADDR_BYTE3: if (last_op_reg != OP_DIV16) rdata_next = byte_reg[3]; // see RL8
                ADDR_DIVISOR_LOW: begin
                    if (last_op_reg == OP_DIV32 || last_op_reg == OP_DIV16) rdata_next = byte_reg[4]; // see RL9
                end
                ADDR_DIVISOR_HIGH: begin
                    if (last_op_reg == OP_DIV32 || last_op_reg == OP_DIV16) rdata_next = byte_reg[5]; // see RL9
                end
                default: rdata_next = READ_UNMAPPED;
            endcase
        end
        if (ADDR == ADDR_ARITH_CONTROL) begin
            rdata_next = {ovf_reg, resp.busy, ctrl_reg};
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= rdata_next;
        end else begin
            RDATA <= 8'h00;
        end
    end

    assign BUSY = resp.busy;

endmodule // muldiv_regs
`default_nettype wire

// [rtl/muldiv_pkg.sv]
// constants and types for the multiply/divide operand and result registers
// Function
// RL1: three byte registers, cleared at reset; the code has six (byte_reg[0:5]), all cleared at reset
// RL2: byte meaning follows the active operation
// RL3: first byte: dividend/quotient or value LSB
// RL4: multiply: first byte multiplicand low, product low
// RL5: multiply: second byte multiplicand high, product byte1
// RL6: second byte per divide, shift, normalize
// RL7: third byte per operation; unused reads zero
// RL8: fourth byte holds most significant byte
// RL9: divisor in, remainder out; multiplier in
// RL10: write order picks operation; results after completion
`default_nettype none
package muldiv_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_BYTE0 = 8'he9;
    localparam logic [7:0] ADDR_BYTE1 = 8'hea;
    localparam logic [7:0] ADDR_BYTE2 = 8'heb;
    localparam logic [7:0] ADDR_BYTE3 = 8'hec;
    localparam logic [7:0] ADDR_DIVISOR_LOW = 8'hed;
    localparam logic [7:0] ADDR_DIVISOR_HIGH = 8'hee;
    localparam logic [7:0] ADDR_ARITH_CONTROL = 8'hef;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // arith_control fields
    localparam int CTRL_OVF_BIT = 7;
    localparam int CTRL_BUSY_BIT = 6;
    localparam int CTRL_DIR_BIT = 5;
    localparam int CTRL_COUNT_MSB = 4;
    localparam logic [5:0] CTRL_RW_RESET = 6'h00;

    // ****************************************
    // widths and step counts
    // ****************************************
    localparam int VALUE_WIDTH = 32;
    localparam int OPER_WIDTH = 16;
    localparam logic [5:0] DIV_STEPS = 6'h20;
    localparam logic [5:0] MUL_STEPS = 6'h10;
    localparam logic [4:0] NORM_MAX = 5'h1f;

    typedef enum logic [4:0] {
        OP_NONE  = 5'b00001,
        OP_DIV32 = 5'b00010,
        OP_DIV16 = 5'b00100,
        OP_MUL   = 5'b01000,
        OP_SHIFT = 5'b10000
    } op_t;

    // progress of the operand write sequence
    typedef enum logic [9:0] {
        SEQ_IDLE  = 10'b0000000001,
        SEQ_W0    = 10'b0000000010,
        SEQ_W01   = 10'b0000000100,
        SEQ_W012  = 10'b0000001000,
        SEQ_W0123 = 10'b0000010000,
        SEQ_W0123_4 = 10'b0000100000,
        SEQ_W01_4 = 10'b0001000000,
        SEQ_W04   = 10'b0010000000,
        SEQ_W04_1 = 10'b0100000000,
        SEQ_SPARE = 10'b1000000000
    } seq_t;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_RUN  = 3'b010,
        ENG_DONE = 3'b100
    } eng_state_t;

    typedef struct packed {
        logic start;
        op_t op;
        logic [31:0] value;
        logic [15:0] operand;
        logic [4:0] count;
        logic dir_right;
    } eng_req_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic [31:0] value;
        logic [15:0] rem;
        logic [4:0] count;
        logic overflow;
    } eng_resp_t;

endpackage
`default_nettype wire

// [rtl/muldiv_engine.sv]
// iterative divide, multiply, shift and normalize engine
`default_nettype none
module muldiv_engine import muldiv_pkg::*; #(
    parameter int VALUE_W = 32,
    parameter int OPER_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request and response
    input wire eng_req_t req,
    output eng_resp_t resp
);

    if (VALUE_W != VALUE_WIDTH || OPER_W != OPER_WIDTH || VALUE_W != 2 * OPER_W) begin : g_bad_widths
        $error("muldiv_engine: unsupported widths");
    end

    eng_state_t state_reg;
    op_t op_reg;
    logic [31:0] acc_reg;
    logic [31:0] mcand_reg;
    logic [16:0] rem_reg;
    logic [15:0] oper_reg;
    logic [5:0] steps_reg;
    logic [4:0] cnt_reg;
    logic dir_reg;
    logic norm_reg;
    logic ovf_reg;

    logic [16:0] rem_shift;
    logic [17:0] diff;
    logic run_last;
    logic norm_stop;

    assign rem_shift = {rem_reg[15:0], acc_reg[31]};
    assign diff = {1'b0, rem_shift} - {2'b00, oper_reg};
    assign norm_stop = acc_reg[31] || (acc_reg == 32'h0000_0000) || (cnt_reg == NORM_MAX);
    assign run_last = norm_reg ? norm_stop : (steps_reg == 6'h00);

    // ****************************************
    // sequencing
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ENG_IDLE;
        end else begin
            case (state_reg)
                ENG_IDLE: if (req.start) state_reg <= ENG_RUN;
                ENG_RUN: if (run_last) state_reg <= ENG_DONE;
                ENG_DONE: state_reg <= ENG_IDLE;
                default: state_reg <= ENG_IDLE;
            endcase
        end
    end

    // ****************************************
    // datapath
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            op_reg <= OP_NONE;
            acc_reg <= 32'h0000_0000;
            mcand_reg <= 32'h0000_0000;
            rem_reg <= 17'h00000;
            oper_reg <= 16'h0000;
            steps_reg <= 6'h00;
            cnt_reg <= 5'h00;
            dir_reg <= 1'b0;
            norm_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else if (state_reg == ENG_IDLE && req.start) begin
            op_reg <= req.op;
            oper_reg <= req.operand;
            rem_reg <= 17'h00000;
            dir_reg <= req.dir_right;
            norm_reg <= (req.op == OP_SHIFT) && (req.count == 5'h00);
            cnt_reg <= 5'h00;
            ovf_reg <= (req.op == OP_DIV32 || req.op == OP_DIV16) && (req.operand == 16'h0000);
            mcand_reg <= {16'h0000, req.value[15:0]};
            // multiply starts from a clear accumulator, the rest from the value
            acc_reg <= (req.op == OP_MUL) ? 32'h0000_0000 : req.value;
            case (req.op)
                OP_DIV32, OP_DIV16: steps_reg <= DIV_STEPS;
                OP_MUL: steps_reg <= MUL_STEPS;
                default: steps_reg <= {1'b0, req.count};
            endcase
        end else if (state_reg == ENG_RUN && !run_last) begin
            steps_reg <= steps_reg - 6'h01;
            case (op_reg)
                OP_DIV32, OP_DIV16: begin
                    // restoring division, one quotient bit per cycle
                    if (!diff[17]) begin
                        rem_reg <= diff[16:0];
                        acc_reg <= {acc_reg[30:0], 1'b1};
                    end else begin
                        rem_reg <= rem_shift;
                        acc_reg <= {acc_reg[30:0], 1'b0};
                    end
                end
                OP_MUL: begin
                    if (oper_reg[0]) acc_reg <= acc_reg + mcand_reg;
                    mcand_reg <= {mcand_reg[30:0], 1'b0};
                    oper_reg <= {1'b0, oper_reg[15:1]};
                end
                OP_SHIFT: begin
                    if (norm_reg || !dir_reg) acc_reg <= {acc_reg[30:0], 1'b0};
                    else acc_reg <= {1'b0, acc_reg[31:1]};
                    if (norm_reg) cnt_reg <= cnt_reg + 5'h01;
                end
                default: acc_reg <= acc_reg;
            endcase
        end else if (state_reg == ENG_RUN && op_reg == OP_MUL) begin
            ovf_reg <= acc_reg[31:16] != 16'h0000;
        end
    end

    assign resp.busy = state_reg != ENG_IDLE;
    assign resp.done = state_reg == ENG_DONE;
    assign resp.value = acc_reg;
    assign resp.rem = rem_reg[15:0];
    assign resp.count = cnt_reg;
    assign resp.overflow = ovf_reg;

endmodule // muldiv_engine
`default_nettype wire

// [tb/muldiv_regs_asserts.sv]
// concurrent checks on the operand and result register port
`default_nettype none
module muldiv_regs_asserts import muldiv_pkg::*; (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // status
    input wire logic BUSY
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // write sequences that start the engine
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence wr_at(a);
        WR && ADDR == a;
    endsequence
    sequence mul_seq;
        wr_at(ADDR_BYTE0) ##1 wr_at(ADDR_DIVISOR_LOW) ##1 wr_at(ADDR_BYTE1) ##1 wr_at(ADDR_DIVISOR_HIGH);
    endsequence
    sequence div32_seq;
        wr_at(ADDR_BYTE0) ##1 wr_at(ADDR_BYTE1) ##1 wr_at(ADDR_BYTE2) ##1 wr_at(ADDR_BYTE3)
            ##1 wr_at(ADDR_DIVISOR_LOW) ##1 wr_at(ADDR_DIVISOR_HIGH);
    endsequence
    sequence shift4_seq;
        wr_at(ADDR_BYTE0) ##1 wr_at(ADDR_BYTE1) ##1 wr_at(ADDR_BYTE2) ##1 wr_at(ADDR_BYTE3)
            ##1 (WR && ADDR == ADDR_ARITH_CONTROL && WDATA[4:0] == 5'h04);
    endsequence

    // ****************************************
    // assertions
    // ****************************************
    a_mul_runs: assert property (mul_seq |-> ##[1:2] BUSY [*8] ##[1:20] !BUSY)
        else $error("multiply did not run and finish in time");
    a_div_runs: assert property (div32_seq |-> ##[1:2] BUSY [*8] ##[16:40] !BUSY)
        else $error("long divide did not run and finish in time");
    a_shift_runs: assert property (shift4_seq |-> ##[1:2] BUSY [*3] ##[1:8] !BUSY)
        else $error("shift by four did not run and finish in time");
    a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside a read answer");
    a_busy_read: assert property (RD && BUSY && ADDR == ADDR_BYTE0 |=> RDATA == 8'h00)
        else $error("result byte visible while engine busy");
    a_unmapped_read: assert property (RD && (ADDR < ADDR_BYTE0 || ADDR > ADDR_ARITH_CONTROL)
        |=> RDATA == READ_UNMAPPED)
        else $error("unmapped read returned data");
    a_busy_cause: assert property ($rose(BUSY) |-> $past(WR) || $past(WR, 2))
        else $error("engine started without a write");
    a_reset_clears: assert property (disable iff (1'b0) RST |=> !BUSY && RDATA == 8'h00)
        else $error("reset did not clear outputs");
endmodule // muldiv_regs_asserts

bind muldiv_regs muldiv_regs_asserts muldiv_regs_asserts_inst (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .BUSY(BUSY));
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the operand and result byte registers
`default_nettype none
module testbench import muldiv_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // signals and design
    // ****************************************
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] RDATA;
    logic BUSY;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #25 CLK = ~CLK;

    muldiv_regs muldiv_regs_inst (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .BUSY(BUSY));

    // ****************************************
    // tasks
    // ****************************************
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a hang anywhere ends the run as a failure
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count = err_count + 1;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        RD <= 1'b0;
    endtask

    task automatic idle();
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        WR <= 1'b0;
        idle();
        @(negedge CLK);
        check(RDATA, exp);
    endtask

    // polls with reads of the first byte so reads during a run get exercised
    task automatic wait_idle();
        int n;
        n = 0;
        idle();
        @(negedge CLK);
        while (BUSY === 1'b1 && n < 100) begin
            @(posedge CLK);
            ADDR <= ADDR_BYTE0;
            RD <= 1'b1;
            @(negedge CLK);
            n++;
        end
        idle();
        check(8'(n == 100), 8'h00);
    endtask

    // byte i of a, d and e sits at bits 47-8*i down
    task automatic run_op(input string name, input logic [47:0] a, input logic [47:0] d, input int n,
        input logic [47:0] e);
        for (int i = 0; i < n; i++) begin
            wr(a[47-8*i -: 8], d[47-8*i -: 8]);
        end
        wait_idle();
        for (int i = 0; i < 6; i++) begin
            rd_check(ADDR_BYTE0 + 8'(i), e[47-8*i -: 8]);
        end
        $display("test %s done", name);
    endtask

    task automatic do_reset();
        @(posedge CLK);
        RST <= 1'b1;
        repeat (5) @(posedge CLK);
        RST <= 1'b0;
    endtask

    task automatic zero_check();
        for (int i = 0; i < 7; i++) begin
            rd_check(ADDR_BYTE0 + 8'(i), BYTE_RESET);
        end
        rd_check(8'he2, READ_UNMAPPED);
        $display("test reset_values done");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        do_reset();
        zero_check();
        run_op("multiply", 48'he9edeaee0000, 48'h347812560000, 4, 48'h600026060000);
        // product wider than 16 bits raises the overflow flag
        rd_check(ADDR_ARITH_CONTROL, 8'h80);
        run_op("divide32", 48'he9eaebecedee, 48'h98badcfe0001, 6, 48'hbadcfe009800);
        run_op("divide16", 48'he9eaedee0000, 48'h351210000000, 4, 48'h230100000500);
        run_op("shift_left", 48'he9eaebecef00, 48'h810000000400, 5, 48'h100800000000);
        run_op("shift_right", 48'he9eaebecef00, 48'h000000812400, 5, 48'h000010080000);
        run_op("normalize", 48'he9eaebecef00, 48'h000001000000, 5, 48'h000000800000);
        rd_check(ADDR_ARITH_CONTROL, 8'h0f);
        // writes out of any known order must not start the engine
        wr(ADDR_BYTE0, 8'h01);
        wr(ADDR_BYTE1, 8'h01);
        wr(ADDR_DIVISOR_HIGH, 8'h01);
        idle();
        @(negedge CLK);
        check({7'h00, BUSY}, 8'h00);
        $display("test broken_order done");
        do_reset();
        zero_check();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
